/* File: design/tctr_regs.svh */
// Purpose: register offsets, field positions, reset values, prescaler width
// Assumes: byte addresses on an 8-bit AXI4-Lite address
// Notes:   channel c sits at (c+1)*0x40, 6-bit offsets below are within it
`ifndef TCTR_REGS_SVH
`define TCTR_REGS_SVH
`define TCTR_OFS_RUN       8'h00
`define TCTR_OFS_LOCK      8'h04
`define TCTR_OFS_CTRL      6'h00
`define TCTR_OFS_MODE      6'h04
`define TCTR_OFS_PINCTL    6'h08
`define TCTR_OFS_IEN       6'h0C
`define TCTR_OFS_FLAG      6'h10
`define TCTR_OFS_CNT       6'h14
`define TCTR_OFS_GR        6'h18
`define TCTR_OFS_GR_END0   6'h24
`define TCTR_OFS_GR_END12  6'h1C
`define TCTR_NCH           3
`define TCTR_CH_BITS       3
`define TCTR_CKS_LSB       0
`define TCTR_CCLR_LSB      3
`define TCTR_CTRL_W        6
`define TCTR_MODE_BFA      0
`define TCTR_MODE_BFB      1
`define TCTR_PIN_CAP       3
`define TCTR_PIN_INIT      2
`define TCTR_FLAG_OVF      4
`define TCTR_FLAG_W        5
`define TCTR_CNT_RST       16'h0000
`define TCTR_CNT_MAX       16'hFFFF
`define TCTR_PRE_W         6
`endif

/* File: design/tctr_pkg.sv */
// Purpose: shared types of the three-channel timer
// Assumes: encodings mirror the control and pin-control fields
// Notes:   unlisted field codes behave as "none"
package tctr_pkg;
   typedef enum logic [2:0] {
      CKS_DIV1  = 3'b000,
      CKS_DIV4  = 3'b001,
      CKS_DIV16 = 3'b010,
      CKS_DIV64 = 3'b011,
      CKS_EXT   = 3'b100
   } tctr_cks_t;
   typedef enum logic [2:0] {
      CLR_NONE = 3'b000,
      CLR_A    = 3'b001,
      CLR_B    = 3'b010,
      CLR_SYNC = 3'b011,
      CLR_C    = 3'b101,
      CLR_D    = 3'b110
   } tctr_clr_t;
   typedef enum logic [1:0] {
      OUT_NONE   = 2'b00,
      OUT_LOW    = 2'b01,
      OUT_HIGH   = 2'b10,
      OUT_TOGGLE = 2'b11
   } tctr_outm_t;
   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10,
      RESP_DECERR = 2'b11
   } tctr_resp_t;
   typedef struct packed {
      logic       hit;
      logic       glob;
      logic       wide;
      logic [1:0] ch;
      logic [5:0] ofs;
   } tctr_dec_t;
endpackage : tctr_pkg

/* File: design/tctr_chan_if.sv */
// Purpose: control and status bundle between timer core and one channel
// Assumes: single clock domain
// Notes:   strobes are one-cycle pulses
`timescale 1ns/1ps
interface tctr_chan_if;
   logic              run;
   logic [5:0]        ctrl;
   logic [1:0]        mode;
   logic [15:0]       pinctl;
   logic              pinctl_wr;
   logic [15:0]       wdata;
   logic              cnt_wr;
   logic [3:0]        gr_wr;
   logic              flag_wr;
   logic              flag_rd;
   logic              sync_clr;
   logic              standby;
   logic [3:0]        tick;
   logic              ext_evt;
   logic [15:0]       count;
   logic [3:0][15:0]  gr;
   logic [4:0]        flags;
   logic              own_clr;
   modport ctl (output run, ctrl, mode, pinctl, pinctl_wr, wdata, cnt_wr,
                gr_wr, flag_wr, flag_rd, sync_clr, standby, tick, ext_evt,
                input count, gr, flags, own_clr);
   modport chan (input run, ctrl, mode, pinctl, pinctl_wr, wdata, cnt_wr,
                 gr_wr, flag_wr, flag_rd, sync_clr, standby, tick, ext_evt,
                 output count, gr, flags, own_clr);
endinterface : tctr_chan_if

/* File: design/tctr_prescale.sv */
// Purpose: count-clock enables at clk/1, /4, /16 and /64
// Assumes: one clock; tick[0] is held high, the other ticks are one-cycle pulses
// Notes:   shared by all channels so lockstep channels tick together
`timescale 1ns/1ps
`include "tctr_regs.svh"
module tctr_prescale (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   output      logic [3:0] tick
);
   logic [`TCTR_PRE_W-1:0] div;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         div <= '0;
      else
         div <= div + 1'b1;
   end

   assign tick[0] = 1'b1;
   genvar k;
   generate
      for (k = 1; k < 4; k++) begin : g_tick
         assign tick[k] = &div[2*k-1:0];
      end
   endgenerate
endmodule : tctr_prescale

/* File: design/tctr_channel.sv */
// Purpose: one timer channel: counter, compare/capture regs, flags, pins
// Assumes: pin inputs synchronous to aclk
// Notes:   NREG is 4 on channel 0, 2 elsewhere
`timescale 1ns/1ps
`include "tctr_regs.svh"
module tctr_channel #(
   parameter int NREG = 4
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   tctr_chan_if.chan       bus,
   input  wire logic [3:0] pin_in,
   output      logic [3:0] pin_out,
   output      logic [3:0] pin_oe
);
   import tctr_pkg::*;

   logic [15:0]      count;
   logic [3:0][15:0] gr;
   logic [3:0][15:0] next_gr;
   logic [4:0]       flags;
   logic [4:0]       arm;
   logic [3:0]       pin_prev;
   logic [3:0]       lvl;
   logic [3:0]       next_lvl;
   logic             evt_prev;
   logic [3:0]       cap_ev;
   logic [3:0]       cmp_ev;
   logic [3:0]       ev;
   tctr_cks_t        cks;
   tctr_clr_t        clr;
   logic             tick_sel;
   logic             tick_en;
   logic             do_clr;
   logic             ovf_ev;
   logic [15:0]      next_count;
   logic [4:0]       flag_clr;

   assign cks = tctr_cks_t'(bus.ctrl[`TCTR_CKS_LSB +: 3]);
   assign clr = tctr_clr_t'(bus.ctrl[`TCTR_CCLR_LSB +: 3]);
   // internal divided clock or external event rising edge
   assign tick_sel = (cks == CKS_EXT) ? (bus.ext_evt & ~evt_prev) :
                     (cks[2] ? 1'b0 : bus.tick[cks[1:0]]);
   assign tick_en  = bus.run & tick_sel;

   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : g_reg
         logic [3:0] p;
         logic       live;
         logic       rise;
         logic       fall;
         assign p    = bus.pinctl[4*r +: 4];
         // buffer regs C/D neither match nor capture on their own
         assign live = (r < NREG) &&
                       !(r == 2 && bus.mode[`TCTR_MODE_BFA]) &&
                       !(r == 3 && bus.mode[`TCTR_MODE_BFB]);
         assign rise = pin_in[r] & ~pin_prev[r];
         assign fall = ~pin_in[r] & pin_prev[r];
         assign cap_ev[r] = live & p[`TCTR_PIN_CAP] & bus.run &
                            ((p[0] & rise) | (p[1] & fall));
         assign cmp_ev[r] = live & ~p[`TCTR_PIN_CAP] & tick_en &
                            (count == gr[r]);
         assign ev[r] = cap_ev[r] | cmp_ev[r];

         always_comb begin
            next_gr[r] = gr[r];
            if (bus.gr_wr[r])
               next_gr[r] = bus.wdata;
            else if (cap_ev[r])
               next_gr[r] = count;
            else if (r == 0 && bus.mode[`TCTR_MODE_BFA] && cmp_ev[0])
               next_gr[r] = gr[2];
            else if (r == 1 && bus.mode[`TCTR_MODE_BFB] && cmp_ev[1])
               next_gr[r] = gr[3];
            else if (r == 2 && bus.mode[`TCTR_MODE_BFA] && cap_ev[0])
               next_gr[r] = gr[0];
            else if (r == 3 && bus.mode[`TCTR_MODE_BFB] && cap_ev[1])
               next_gr[r] = gr[1];
         end

         // level only moves on match or idle reconfiguration
         always_comb begin
            next_lvl[r] = lvl[r];
            if (bus.pinctl_wr && !bus.run)
               next_lvl[r] = bus.wdata[4*r+`TCTR_PIN_INIT];
            else if (cmp_ev[r]) begin
               case (tctr_outm_t'(p[1:0]))
                  OUT_LOW:    next_lvl[r] = 1'b0;
                  OUT_HIGH:   next_lvl[r] = 1'b1;
                  OUT_TOGGLE: next_lvl[r] = ~lvl[r];
                  default:    next_lvl[r] = lvl[r];
               endcase
            end
         end
         assign pin_oe[r] = (r < NREG) && !p[`TCTR_PIN_CAP] &&
                            (p[1:0] != 2'b00);
      end
   endgenerate

   // own clear source, shared with lockstep partners
   assign bus.own_clr = (clr == CLR_A & ev[0]) | (clr == CLR_B & ev[1]) |
                        (clr == CLR_C & ev[2]) | (clr == CLR_D & ev[3]);
   assign do_clr = bus.own_clr | (clr == CLR_SYNC & bus.sync_clr);
   assign ovf_ev = tick_en & (count == `TCTR_CNT_MAX) & ~do_clr &
                   ~bus.cnt_wr;

   always_comb begin
      next_count = count;
      if (bus.standby)
         next_count = `TCTR_CNT_RST;
      else if (bus.cnt_wr)
         next_count = bus.wdata;
      else if (do_clr)
         next_count = `TCTR_CNT_RST;
      else if (tick_en)
         next_count = count + 16'h0001;
   end

   // clear needs a prior read of 1; a same-cycle set wins
   assign flag_clr = {`TCTR_FLAG_W{bus.flag_wr}} & ~bus.wdata[4:0] & arm;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count    <= `TCTR_CNT_RST;
         gr       <= '0;
         flags    <= '0;
         arm      <= '0;
         lvl      <= '0;
         pin_prev <= '0;
         evt_prev <= 1'b0;
      end else begin
         count    <= next_count;
         gr       <= next_gr;
         flags    <= {ovf_ev, ev} | (flags & ~flag_clr);
         arm      <= bus.flag_rd ? flags : (bus.flag_wr ? 5'h00 : arm);
         lvl      <= next_lvl;
         pin_prev <= pin_in;
         evt_prev <= bus.ext_evt;
      end
   end

   assign bus.count = count;
   assign bus.gr    = gr;
   assign bus.flags = flags;
   assign pin_out   = lvl;
endmodule : tctr_channel

/* File: design/tctr_top.sv */
// Purpose: three-channel 16-bit timer with AXI4-Lite register access
// Assumes: all pin inputs synchronous to aclk; 16-bit regs sit in low half
// Notes:   writes to 16-bit regs lacking either low byte lane are refused with SLVERR
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tctr_regs.svh"
module tctr_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          awaddr,
   input  wire logic                awvalid,
   output      logic                awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output      logic                wready,
   output      logic [1:0]          bresp,
   output      logic                bvalid,
   input  wire logic                bready,
   input  wire logic [7:0]          araddr,
   input  wire logic                arvalid,
   output      logic                arready,
   output      logic [31:0]         rdata,
   output      logic [1:0]          rresp,
   output      logic                rvalid,
   input  wire logic                rready,
   input  wire logic                hw_standby,
   input  wire logic [2:0]          count_event_pin,
   input  wire logic [11:0]         timer_io_pin_in,
   output      logic [11:0]         timer_io_pin_out,
   output      logic [11:0]         timer_io_pin_oe,
   output      logic [2:0]          irq_req
);
   import tctr_pkg::*;

   // address decode shared by the write and read paths
   function automatic tctr_dec_t tctr_decode(input logic [7:0] a);
      tctr_dec_t d;
      d.glob = (a[7:6] == 2'b00);
      d.ch   = a[7:6] - 2'b01;
      d.ofs  = a[5:0];
      d.wide = (d.ofs >= `TCTR_OFS_CNT) || (d.ofs == `TCTR_OFS_PINCTL);
      if (d.glob)
         d.hit = (a == `TCTR_OFS_RUN) || (a == `TCTR_OFS_LOCK);
      else
         d.hit = (d.ofs[1:0] == 2'b00) &&
                 (d.ofs <= ((d.ch == 2'b00) ? `TCTR_OFS_GR_END0
                                            : `TCTR_OFS_GR_END12));
      return d;
   endfunction : tctr_decode

   logic [2:0]              run;
   logic [2:0]              lock;
   logic [5:0]              ctrl   [3];
   logic [1:0]              mode   [3];
   logic [15:0]             pinctl [3];
   logic [4:0]              ien    [3];
   logic [3:0]              tick;
   logic [2:0]              own_clr;
   logic [31:0]             rd_ch  [3];

   logic                    aw_held;
   logic                    w_held;
   logic [7:0]              aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   tctr_dec_t               wd;
   tctr_dec_t               rd;
   logic                    do_wr;
   logic                    wr_ok;
   logic                    wr_go;
   logic                    wr_lo;
   tctr_resp_t              wr_resp;
   logic                    rd_take;
   logic [31:0]             rd_val;
   tctr_resp_t              rd_resp;

   // ---------------- AXI4-Lite write path
   assign awready = ~aw_held & ~bvalid;
   assign wready  = ~w_held & ~bvalid;
   assign do_wr   = aw_held & w_held & ~bvalid;
   assign wd      = tctr_decode(aw_addr);
   // 16-bit regs need both low byte lanes, else refused
   assign wr_ok   = wd.hit & (~wd.wide | (&w_strb[1:0]));
   assign wr_go   = do_wr & wr_ok;
   assign wr_lo   = wr_go & w_strb[0];
   assign wr_resp = !wd.hit ? RESP_DECERR :
                    (wr_ok ? RESP_OKAY : RESP_SLVERR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= 2'b00;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (do_wr) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_resp;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // ---------------- global run and lockstep registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run  <= 3'b000;
         lock <= 3'b000;
      end else if (wr_lo && wd.glob) begin
         // upper bits are not stored and read back as zero
         if (aw_addr == `TCTR_OFS_RUN)
            run <= w_data[`TCTR_CH_BITS-1:0];
         if (aw_addr == `TCTR_OFS_LOCK)
            lock <= w_data[`TCTR_CH_BITS-1:0];
      end
   end

   tctr_prescale u_pre (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   // ---------------- AXI4-Lite read path
   assign arready = ~rvalid;
   assign rd_take = arvalid & arready;
   assign rd      = tctr_decode(araddr);
   assign rd_resp = rd.hit ? RESP_OKAY : RESP_DECERR;
   assign rd_val  = !rd.hit ? 32'h0000_0000 :
                    rd.glob ? {29'h0, (araddr == `TCTR_OFS_RUN) ? run : lock}
                            : rd_ch[rd.ch];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= 2'b00;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata  <= rd_val;
         rresp  <= rd_resp;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------- channels
   genvar c;
   generate
      for (c = 0; c < `TCTR_NCH; c++) begin : g_ch
         tctr_chan_if chif ();
         logic       sel;
         logic [1:0] gi;
         logic [2:0] others;

         assign sel    = wr_go & ~wd.glob & (wd.ch == c);
         assign others = lock & ~(3'b001 << c);
         assign gi     = 2'((rd.ofs - `TCTR_OFS_GR) >> 2);

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ctrl[c]   <= '0;
               mode[c]   <= '0;
               pinctl[c] <= '0;
               ien[c]    <= '0;
            end else if (sel) begin
               if (w_strb[0] && wd.ofs == `TCTR_OFS_CTRL)
                  ctrl[c] <= w_data[`TCTR_CTRL_W-1:0];
               if (w_strb[0] && wd.ofs == `TCTR_OFS_MODE && c == 0)
                  mode[c] <= w_data[1:0];
               if (wd.ofs == `TCTR_OFS_PINCTL)
                  pinctl[c] <= w_data[15:0];
               if (w_strb[0] && wd.ofs == `TCTR_OFS_IEN)
                  ien[c] <= w_data[`TCTR_FLAG_W-1:0];
            end
         end

         always_ff @(posedge aclk) begin
            if (!aresetn)
               irq_req[c] <= 1'b0;
            else
               irq_req[c] <= |(chif.flags & ien[c]);
         end

         assign chif.run       = run[c];
         assign chif.ctrl      = ctrl[c];
         assign chif.mode      = mode[c];
         assign chif.pinctl    = pinctl[c];
         assign chif.pinctl_wr = sel & (wd.ofs == `TCTR_OFS_PINCTL);
         assign chif.wdata     = w_data[15:0];
         // one write presets every lockstep partner too
         assign chif.cnt_wr    = wr_go & ~wd.glob &
                                 (wd.ofs == `TCTR_OFS_CNT) &
                                 ((wd.ch == c) |
                                  (lock[c] & lock[wd.ch]));
         assign chif.flag_wr   = sel & w_strb[0] &
                                 (wd.ofs == `TCTR_OFS_FLAG);
         assign chif.flag_rd   = rd_take & rd.hit & ~rd.glob &
                                 (rd.ch == c) &
                                 (rd.ofs == `TCTR_OFS_FLAG);
         assign chif.sync_clr  = lock[c] & |(own_clr & others);
         assign chif.standby   = hw_standby;
         assign chif.tick      = tick;
         assign chif.ext_evt   = count_event_pin[c];
         assign own_clr[c]     = chif.own_clr;

         for (genvar r = 0; r < 4; r++) begin : g_gw
            assign chif.gr_wr[r] = sel & (wd.ofs == `TCTR_OFS_GR + 6'(4*r));
         end

         always_comb begin
            rd_ch[c] = 32'h0000_0000;
            case (rd.ofs)
               `TCTR_OFS_CTRL:   rd_ch[c][5:0]  = ctrl[c];
               `TCTR_OFS_MODE:   rd_ch[c][1:0]  = mode[c];
               `TCTR_OFS_PINCTL: rd_ch[c][15:0] = pinctl[c];
               `TCTR_OFS_IEN:    rd_ch[c][4:0]  = ien[c];
               `TCTR_OFS_FLAG:   rd_ch[c][4:0]  = chif.flags;
               `TCTR_OFS_CNT:    rd_ch[c][15:0] = chif.count;
               default:          rd_ch[c][15:0] = chif.gr[gi];
            endcase
         end

         tctr_channel #(
            .NREG ((c == 0) ? 4 : 2)
         ) u_ch (
            .aclk    (aclk),
            .aresetn (aresetn),
            .bus     (chif.chan),
            .pin_in  (timer_io_pin_in[4*c +: 4]),
            .pin_out (timer_io_pin_out[4*c +: 4]),
            .pin_oe  (timer_io_pin_oe[4*c +: 4])
         );
      end
   endgenerate
endmodule : tctr_top

/* File: test/tctr_top_sva.sv */
// Purpose: bus and pin relations of the timer top
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every tctr_top instance
`timescale 1ns/1ps
module tctr_top_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic [11:0] timer_io_pin_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_b_late;
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
   endproperty
   a_b_late: assert property (p_b_late) else $error("bvalid timing");
   property p_w_blk;
      bvalid |-> !awready && !wready;
   endproperty
   a_w_blk: assert property (p_w_blk) else $error("write taken early");
   property p_r_ans;
      arvalid && arready |=> rvalid;
   endproperty
   a_r_ans: assert property (p_r_ans) else $error("no read answer");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_r_blk;
      rvalid |-> !arready;
   endproperty
   a_r_blk: assert property (p_r_blk) else $error("read taken early");
   property p_upper;
      rvalid |-> rdata[31:16] == 16'h0000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper half set");
   property p_decerr;
      arvalid && arready && araddr == 8'hFC |=> rresp == 2'h3 && rdata == 0;
   endproperty
   a_decerr: assert property (p_decerr) else $error("unmapped read");
   property p_oe;
      $changed(timer_io_pin_oe) |-> $rose(bvalid);
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable moved");
endmodule : tctr_top_sva
bind tctr_top tctr_top_sva u_sva (.*);

/* File: test/tctr_top_tb.sv */
// Purpose: self-checking bench of the three-channel timer
// Assumes: AXI4-Lite master in the bench, 100 MHz clock
// Notes:   pin and event inputs low except in the capture scenario
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tctr_top_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        hw_standby, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [2:0]  count_event_pin, irq_req;
   logic [11:0] timer_io_pin_in, timer_io_pin_out, timer_io_pin_oe;
   int          n_fail = 0;
   int          checks = 0;
   tctr_top dut (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                     input logic [3:0] s, output logic [1:0] rs);
      int   n;
      logic ha, hw, hb;
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, dv, s};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      if (n == 50) begin n_fail++; wrap_up(); end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                     output logic [1:0] rs);
      int   n;
      logic ha, hr;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 50; n++) begin
         @(negedge aclk);
         ha = arvalid & arready;
         hr = rvalid;
         dv = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hr) break;
      end
      rready <= 1'b0;
      if (n == 50) begin n_fail++; wrap_up(); end
   endtask : rd
   task automatic wo(input logic [7:0] a, input logic [31:0] dv);
      wr(a, dv, 4'hF, r);
      `CHK("write resp", 2'h0, r)
   endtask : wo
   task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                      input string nm);
      rd(a, d, r);
      `CHK(nm, {16'h0000, e}, d)
   endtask : rdc
   task automatic t_count;
      rdc(8'h54, 16'h0000, "count at reset");
      rdc(8'h00, 16'h0000, "run at reset");
      wo(8'h00, 32'h1);
      wo(8'h00, 32'h0);
      rd(8'h54, d, r);
      `CHK("count moved", 1'b1, d != 0)
      repeat (5) @(posedge aclk);
      rdc(8'h54, d[15:0], "halted count");
      wo(8'h54, 32'hFFFE);
      rdc(8'h54, 16'hFFFE, "count write");
   endtask : t_count
   task automatic t_ovf;
      wo(8'h4C, 32'h10);
      wo(8'h00, 32'h1);
      repeat (4) @(posedge aclk);
      wo(8'h00, 32'h0);
      `CHK("ovf irq", 1'b1, irq_req[0])
      rd(8'h54, d, r);
      `CHK("wrapped count", 1'b1, d < 32'h40)
      wo(8'h50, 32'h10);
      rd(8'h50, d, r);
      `CHK("flag kept", 1'b1, d[4])
      wo(8'h50, 32'h0);
      rd(8'h50, d, r);
      `CHK("flag cleared", 1'b0, d[4])
      `CHK("irq dropped", 1'b0, irq_req[0])
   endtask : t_ovf
   task automatic t_per;
      wo(8'h80, 32'h08);
      wo(8'h98, 32'h5);
      wo(8'h88, 32'h5);
      `CHK("init level", 1'b1, timer_io_pin_out[4])
      `CHK("pin driven", 1'b1, timer_io_pin_oe[4])
      wo(8'h8C, 32'h1);
      wo(8'h00, 32'h2);
      repeat (20) @(posedge aclk);
      wo(8'h00, 32'h0);
      rd(8'h94, d, r);
      `CHK("period count", 1'b1, d <= 32'h5)
      rd(8'h90, d, r);
      `CHK("match flag", 1'b1, d[0])
      `CHK("match irq", 1'b1, irq_req[1])
      `CHK("low kept", 1'b0, timer_io_pin_out[4])
      wo(8'h88, 32'h6);
      `CHK("new level", 1'b1, timer_io_pin_out[4])
   endtask : t_per
   task automatic t_sync;
      wo(8'h04, 32'h6);
      wo(8'h94, 32'h1234);
      rdc(8'hD4, 16'h1234, "preset together");
      wo(8'h04, 32'h0);
      wo(8'hD4, 32'h55);
      rdc(8'h94, 16'h1234, "independent");
      hw_standby <= 1'b1;
      repeat (2) @(posedge aclk);
      hw_standby <= 1'b0;
      rdc(8'hD4, 16'h0000, "standby zero");
      rd(8'hFC, d, r);
      `CHK("unmapped resp", 2'h3, r)
      wr(8'h98, 32'hABCD, 4'h1, r);
      `CHK("byte resp", 2'h2, r)
      rdc(8'h98, 16'h0005, "byte ignored");
      wo(8'hC0, 32'h18);
      wo(8'h04, 32'h6);
      wo(8'h00, 32'h6);
      repeat (22) @(posedge aclk);
      wo(8'h00, 32'h0);
      rdc(8'hD4, 16'h0002, "sync clear");
      wo(8'hC0, 32'h01);
      wo(8'hD4, 32'h0);
      wo(8'h00, 32'h4);
      repeat (20) @(posedge aclk);
      wo(8'h00, 32'h0);
      rdc(8'hD4, 16'h0006, "div4 count");
   endtask : t_sync
   task automatic t_cap;
      wo(8'h44, 32'h1);
      wo(8'h58, 32'hAA);
      wo(8'h48, 32'h9);
      wo(8'h40, 32'h4);
      wo(8'h00, 32'h1);
      repeat (3) begin
         @(posedge aclk);
         count_event_pin[0] <= 1'b1;
         @(posedge aclk);
         count_event_pin[0] <= 1'b0;
      end
      @(posedge aclk);
      timer_io_pin_in[0] <= 1'b1;
      wo(8'h00, 32'h0);
      rdc(8'h54, 16'h0003, "event count");
      rdc(8'h58, 16'h0003, "captured");
      rdc(8'h60, 16'h00AA, "buffered");
   endtask : t_cap
   task automatic wrap_up;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby} = '0;
      {awaddr, araddr, wdata, wstrb, count_event_pin, timer_io_pin_in} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_count();
      t_ovf();
      t_per();
      t_sync();
      t_cap();
      wrap_up();
   end
endmodule : tctr_top_tb
